// *** core/timer_pkg.sv ***
// Constants and types shared by the timer/event counter with capture
// What this block does
// - Interval mode: counter equal to compare clears to 0, keeps counting, raises compare irq.
// - Count clock chosen by prescaler mode bits 1:0.
// - Interval equals compare value plus one count clock periods; compare 0001H..FFFFH.
// - Clear modes set overflow whenever the count passes FFFFH: compare holds FFFFH, or compare was lowered below count.
// - Compare lowered below count: counter runs on, wraps, restarts at 0.
// - Event mode: counter steps once per valid edge of input a.
// - Event mode: count equal to compare clears to 0 and raises compare irq.
// - Input a edge type from prescaler mode bits 5:4.
// - Event mode samples input a every clock; edge accepted after two equal samples.
// - After event start, counting begins only after a filtered valid edge.
// - Capture inputs sampled on the count clock; two equal samples before capture.
// - Free-running: input a edge latches counter into register b, raises its irq.
// - Input b edge latches counter into register a, raises compare/capture irq.
// - Input b edge type from prescaler mode bits 7:6.
// - Free-running wrap sets the overflow flag.
// - Clock select: 00 clock, 01 clock/4, 10 clock/256, 11 input a edges.
// - Edge select: 00 falling, 01 rising, 11 both, 10 prohibited.
package timer_pkg;

    localparam int CNT_W = 16;
    localparam int DIV_W = 8;

    // Prescaler mode register field positions
    localparam int CKSEL_LSB = 0;
    localparam int EDGE_A_LSB = 4;
    localparam int EDGE_B_LSB = 6;

    // Capture/compare control bit: register a captures on input b
    localparam int CAP_A_BIT = 0;

    // Values after reset, and the counter top value
    localparam logic [CNT_W-1:0] COUNT_RST = 16'h0000;
    localparam logic [CNT_W-1:0] COUNT_MAX = 16'hFFFF;
    localparam logic [CNT_W-1:0] REG_RST = 16'h0000;
    localparam logic [DIV_W-1:0] DIV_RST = 8'h00;

    // Divider terminal values for the prescaled clocks
    localparam logic [DIV_W-1:0] DIV4_MASK = 8'h03;
    localparam logic [DIV_W-1:0] DIV256_MASK = 8'hFF;

    typedef enum logic [1:0] {
        CK_FULL,
        CK_DIV4,
        CK_DIV256,
        CK_EDGE_A
    } clock_sel_t;

    typedef enum logic [1:0] {
        EDGE_FALL,
        EDGE_RISE,
        EDGE_BAD,
        EDGE_BOTH
    } edge_sel_t;

    // Timer mode control values
    typedef enum logic [1:0] {
        MODE_STOP,
        MODE_FREE,
        MODE_CLEAR,
        MODE_RSVD
    } op_mode_t;

    typedef struct packed {
        logic prev;
        logic level;
        logic edge_seen;
    } filter_state_t;

    typedef struct packed {
        logic [CNT_W-1:0] counter;
        logic [CNT_W-1:0] reg_a;
        logic [CNT_W-1:0] reg_b;
        logic [DIV_W-1:0] div;
        logic ovf;
        logic irq_a;
        logic irq_b;
    } timer_state_t;

endpackage

// *** core/edge_filter.sv ***
// Two-sample noise eliminator and valid edge detector for one timer input
`timescale 1ns/10ps
`default_nettype none
module edge_filter
    import timer_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic reset_i,
    // Control
    input wire logic enable_i,
    input wire logic sample_i,
    input wire logic [1:0] edge_sel_i,
    // Pin and result
    input wire logic pin_i,
    output logic valid_edge_o
);

    filter_state_t state;
    filter_state_t next_state;
    logic rise;
    logic fall;

    always_comb begin
        next_state = state;
        next_state.edge_seen = 1'b0;
        rise = 1'b0;
        fall = 1'b0;
        if (!enable_i) begin
            // Stopped: level forced low so a high pin is seen as rising on start
            next_state.prev = 1'b0;
            next_state.level = 1'b0;
        end else if (sample_i) begin
            next_state.prev = pin_i;
            if (pin_i == state.prev && pin_i != state.level) begin
                next_state.level = pin_i;
                rise = pin_i;
                fall = !pin_i;
            end
            case (edge_sel_i)
                EDGE_FALL: next_state.edge_seen = fall;
                EDGE_RISE: next_state.edge_seen = rise;
                EDGE_BOTH: next_state.edge_seen = rise | fall;
                default: next_state.edge_seen = 1'b0;
            endcase
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign valid_edge_o = state.edge_seen;

endmodule
`default_nettype wire

// *** core/timer_event_counter_capture.sv ***
// Timer/event counter with compare match and dual capture
`timescale 1ns/10ps
`default_nettype none
module timer_event_counter_capture
    import timer_pkg::*;
#(
    parameter int COUNT_WIDTH = 16
)(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic reset_i,
    // Timer mode control
    input wire logic [1:0] timer_mode_control_i,
    // Capture/compare control
    input wire logic [7:0] capture_compare_control_i,
    // Prescaler mode register
    input wire logic [7:0] prescaler_mode_reg_i,
    // Compare register write
    input wire logic compare_wr_i,
    input wire logic [COUNT_WIDTH-1:0] compare_data_i,
    // Overflow flag clear
    input wire logic overflow_clr_i,
    // Timer input pins
    input wire logic timer_input_a_i,
    input wire logic timer_input_b_i,
    // Counter and register contents
    output logic [COUNT_WIDTH-1:0] main_counter_o,
    output logic [COUNT_WIDTH-1:0] compare_capture_reg_a_o,
    output logic [COUNT_WIDTH-1:0] capture_reg_b_o,
    // Status and interrupt requests
    output logic overflow_flag_o,
    output logic compare_a_irq_o,
    output logic capture_b_irq_o
);

    // Refused at elaboration: the logic serves only the 16-bit counter
    if (COUNT_WIDTH != CNT_W) begin
        $error("COUNT_WIDTH must equal the 16-bit counter width");
    end

    timer_state_t state;
    timer_state_t next_state;

    op_mode_t mode;
    clock_sel_t clock_sel;
    edge_sel_t edge_a_sel;
    edge_sel_t edge_b_sel;

    logic running;
    logic event_mode;
    logic cap_a_enable;
    logic div_tick;
    logic count_tick;
    logic sample_tick;
    logic edge_a;
    logic edge_b;
    logic match;
    logic wrap;

    // Field decode
    always_comb begin
        mode = op_mode_t'(timer_mode_control_i);
        clock_sel = clock_sel_t'(prescaler_mode_reg_i[CKSEL_LSB +: 2]);
        edge_a_sel = edge_sel_t'(prescaler_mode_reg_i[EDGE_A_LSB +: 2]);
        edge_b_sel = edge_sel_t'(prescaler_mode_reg_i[EDGE_B_LSB +: 2]);
        cap_a_enable = capture_compare_control_i[CAP_A_BIT];
        running = (mode == MODE_FREE) || (mode == MODE_CLEAR);
        event_mode = (clock_sel == CK_EDGE_A);
    end

    // Count clock selection
    always_comb begin
        case (clock_sel)
            CK_FULL: div_tick = 1'b1;
            CK_DIV4: div_tick = ((state.div & DIV4_MASK) == DIV4_MASK);
            CK_DIV256: div_tick = ((state.div & DIV256_MASK) == DIV256_MASK);
            default: div_tick = 1'b0;
        endcase
    end

    // Event counting filters every clock, capture on the count clock
    always_comb begin
        if (event_mode) begin
            sample_tick = 1'b1;
            count_tick = edge_a;
        end else begin
            sample_tick = div_tick;
            count_tick = div_tick;
        end
    end

    edge_filter filter_a (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .enable_i(running),
        .sample_i(sample_tick),
        .edge_sel_i(edge_a_sel),
        .pin_i(timer_input_a_i),
        .valid_edge_o(edge_a)
    );

    edge_filter filter_b (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .enable_i(running),
        .sample_i(sample_tick),
        .edge_sel_i(edge_b_sel),
        .pin_i(timer_input_b_i),
        .valid_edge_o(edge_b)
    );

    always_comb begin
        match = !cap_a_enable && (state.counter == state.reg_a);
        wrap = (state.counter == COUNT_MAX);
    end

    always_comb begin
        next_state = state;
        next_state.irq_a = 1'b0;
        next_state.irq_b = 1'b0;

        // Software clear first, so a hardware set below wins
        if (overflow_clr_i) begin
            next_state.ovf = 1'b0;
        end

        // Prescaler divider runs only while the timer runs
        if (running) begin
            next_state.div = state.div + 8'h01;
        end else begin
            next_state.div = DIV_RST;
        end

        // Compare register write, ignored while register a captures
        if (compare_wr_i && !cap_a_enable) begin
            next_state.reg_a = compare_data_i;
        end

        if (!running) begin
            next_state.counter = COUNT_RST;
        end else if (count_tick) begin
            if (mode == MODE_CLEAR && match) begin
                next_state.counter = COUNT_RST;
                next_state.irq_a = 1'b1;
                if (wrap) begin
                    next_state.ovf = 1'b1;
                end
            end else if (wrap) begin
                next_state.counter = COUNT_RST;
                next_state.ovf = 1'b1;
            end else begin
                next_state.counter = state.counter + 16'h0001;
                if (mode == MODE_FREE && match) begin
                    next_state.irq_a = 1'b1;
                end
            end
        end

        // Captures latch the whole counter value at once
        if (running && !event_mode) begin
            if (edge_a) begin
                next_state.reg_b = state.counter;
                next_state.irq_b = 1'b1;
            end
            if (edge_b && cap_a_enable) begin
                next_state.reg_a = state.counter;
                next_state.irq_a = 1'b1;
            end
        end

    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            state <= '{counter: COUNT_RST, reg_a: REG_RST, reg_b: REG_RST,
                       div: DIV_RST, ovf: 1'b0, irq_a: 1'b0, irq_b: 1'b0};
        end else begin
            state <= next_state;
        end
    end

    // Outputs straight from state flip-flops
    assign main_counter_o = state.counter;
    assign compare_capture_reg_a_o = state.reg_a;
    assign capture_reg_b_o = state.reg_b;
    assign overflow_flag_o = state.ovf;
    assign compare_a_irq_o = state.irq_a;
    assign capture_b_irq_o = state.irq_b;

endmodule
`default_nettype wire

// *** tb/pulse_source.sv ***
// Far-side source that drives both timer input pins
`timescale 1ns/10ps
`default_nettype none
module pulse_source (
    // Clock
    input wire logic core_clk_i,
    // Timer input pins
    output logic timer_input_a_o,
    output logic timer_input_b_o
);
    initial begin
        timer_input_a_o = 1'b0;
        timer_input_b_o = 1'b0;
    end
    // Holds both pins for n clocks; widths stay far inside one counter cycle
    task automatic drive(input logic [1:0] lv, input int n);
        @(posedge core_clk_i);
        timer_input_a_o <= lv[0];
        timer_input_b_o <= lv[1];
        repeat (n - 1) @(posedge core_clk_i);
    endtask
endmodule
`default_nettype wire

// *** tb/timer_monitor.sv ***
// Port checker for the timer, bound to every timer instance
`timescale 1ns/10ps
`default_nettype none
module timer_monitor
    import timer_pkg::*;
#(
    parameter int COUNT_WIDTH = 16
)(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic reset_i,
    // Controls and pin
    input wire logic [1:0] timer_mode_control_i,
    input wire logic [7:0] capture_compare_control_i,
    input wire logic [7:0] prescaler_mode_reg_i,
    input wire logic timer_input_a_i,
    // Timer outputs
    input wire logic [COUNT_WIDTH-1:0] main_counter_o,
    input wire logic [COUNT_WIDTH-1:0] compare_capture_reg_a_o,
    input wire logic [COUNT_WIDTH-1:0] capture_reg_b_o,
    input wire logic overflow_flag_o,
    input wire logic compare_a_irq_o,
    input wire logic capture_b_irq_o
);
    logic [1:0] md;
    logic [1:0] ck;
    logic [15:0] cnt;
    logic [15:0] ra;
    assign md = timer_mode_control_i;
    assign ck = prescaler_mode_reg_i[1:0];
    assign cnt = main_counter_o;
    assign ra = compare_capture_reg_a_o;
    default clocking mon_cb @(posedge core_clk_i);
    endclocking
    default disable iff (reset_i);
    sequence s_evt_step;
        md == 2'h2 && $past(md) == 2'h2 && ck == 2'h3 && $changed(cnt) && cnt != 16'h0000;
    endsequence
    sequence s_pin_held;
        $past(timer_input_a_i, 2) == $past(timer_input_a_i, 3);
    endsequence
    AST_CLR_MATCH: assert property (
        md == 2'h2 && $past(md) == 2'h2 && $past(ck) == 2'h0 && $past(cnt) == $past(ra)
        |-> cnt == 16'h0000 && compare_a_irq_o) else $error("no clear on match");
    AST_FREE_INC: assert property (
        md == 2'h1 && $past(md) == 2'h1 && ck == 2'h0 && $past(ck) == 2'h0
        |-> cnt == $past(cnt) + 16'h0001) else $error("free count no step");
    AST_DIV4: assert property (
        md != 2'h0 && ck == 2'h1 && $changed(cnt)
        |=> (md == 2'h0 || ck != 2'h1 || $stable(cnt))[*3]) else $error("div4 broken");
    AST_WRAP_OVF: assert property (
        md != 2'h0 && $past(md) != 2'h0 && $past(cnt) == 16'hFFFF && cnt == 16'h0000
        |-> overflow_flag_o) else $error("wrap without overflow");
    AST_OVF_HOLD: assert property (
        $past(md) == 2'h2 && !$past(overflow_flag_o) && $past(cnt) < $past(ra)
        |-> !overflow_flag_o) else $error("overflow below compare");
    AST_CAP_B: assert property (
        capture_b_irq_o |-> capture_reg_b_o == $past(cnt)) else $error("bad b capture");
    AST_CAP_A: assert property (
        compare_a_irq_o && md == 2'h1 && capture_compare_control_i[CAP_A_BIT]
        |-> ra == $past(cnt)) else $error("bad a capture");
    AST_EVT_FILTER: assert property (
        s_evt_step |-> s_pin_held) else $error("unfiltered event");
endmodule
bind timer_event_counter_capture timer_monitor #(.COUNT_WIDTH(COUNT_WIDTH)) mon_u (.*);
`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking bench for the timer with event counting and capture
`timescale 1ns/10ps
`default_nettype none
`define CHK(what, exp, got) \
    tests_run++; \
    if ((got) !== (exp)) begin \
        fail_count++; \
        $display("[FAIL] %s expected %h seen %h", what, exp, got); \
    end
module tb_top;
    logic core_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [1:0] mode = 2'h0;
    logic [7:0] ctrl = 8'h00;
    logic [7:0] prm = 8'h00;
    logic cwr = 1'b0;
    logic [15:0] cdata = 16'h0000;
    logic oclr = 1'b0;
    logic pin_a;
    logic pin_b;
    logic [15:0] cnt;
    logic [15:0] ra;
    logic [15:0] rb;
    logic ovf;
    logic irq_a;
    logic irq_b;
    int irq_b_n = 0;
    logic [7:0] iv_prm [4] = '{8'h00, 8'h01, 8'h00, 8'h02};
    logic [15:0] iv_cmp [4] = '{16'h0005, 16'h0001, 16'h0001, 16'h0001};
    int iv_gap [4] = '{6, 8, 2, 512};
    logic [15:0] ev_exp [4] = '{16'h0002, 16'h0002, 16'h0000, 16'h0004};
    int fail_count = 0;
    int tests_run = 0;
    int n;
    pulse_source src_u (.core_clk_i(core_clk_i), .timer_input_a_o(pin_a), .timer_input_b_o(pin_b));
    timer_event_counter_capture dut_u (
        .core_clk_i(core_clk_i), .reset_i(reset_i), .timer_mode_control_i(mode),
        .capture_compare_control_i(ctrl), .prescaler_mode_reg_i(prm),
        .compare_wr_i(cwr), .compare_data_i(cdata), .overflow_clr_i(oclr),
        .timer_input_a_i(pin_a), .timer_input_b_i(pin_b), .main_counter_o(cnt),
        .compare_capture_reg_a_o(ra), .capture_reg_b_o(rb), .overflow_flag_o(ovf),
        .compare_a_irq_o(irq_a), .capture_b_irq_o(irq_b)
    );
    initial begin
        forever #4 core_clk_i = ~core_clk_i;
    end
    // Counts capture b interrupt pulses
    always @(negedge core_clk_i) begin
        if (irq_b === 1'b1) begin
            irq_b_n++;
        end
    end
    // Stop, then control, compare, prescaler, and mode last
    task automatic setup(input logic [1:0] m, input logic [7:0] c, input logic [7:0] p,
            input logic [15:0] v);
        @(posedge core_clk_i);
        mode <= 2'h0;
        ctrl <= c;
        @(posedge core_clk_i);
        cwr <= 1'b1;
        cdata <= v;
        @(posedge core_clk_i);
        cwr <= 1'b0;
        prm <= p;
        @(posedge core_clk_i);
        mode <= m;
    endtask
    task automatic gap(output int k);
        k = 0;
        do begin
            @(negedge core_clk_i);
            k++;
        end while (irq_a !== 1'b1 && k < 2000);
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge core_clk_i);
        reset_i <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            setup(2'h2, 8'h00, iv_prm[i], iv_cmp[i]);
            gap(n);
            gap(n);
            `CHK("interval", iv_gap[i], n)
            `CHK("overflow", 1'b0, ovf)
        end
        $display("test interval done");
        setup(2'h2, 8'h00, 8'h00, 16'h0010);
        repeat (10) @(posedge core_clk_i);
        cwr <= 1'b1;
        cdata <= 16'h0002;
        @(posedge core_clk_i);
        cwr <= 1'b0;
        n = 0;
        while (ovf !== 1'b1 && n < 70000) begin
            @(negedge core_clk_i);
            n++;
        end
        `CHK("wrap overflow", 1'b1, ovf)
        `CHK("wrap count", 16'h0000, cnt)
        @(posedge core_clk_i);
        oclr <= 1'b1;
        @(posedge core_clk_i);
        oclr <= 1'b0;
        gap(n);
        gap(n);
        `CHK("new interval", 3, n)
        `CHK("overflow clear", 1'b0, ovf)
        $display("test lowered compare done");
        for (int i = 0; i < 4; i++) begin
            setup(2'h2, 8'h00, {2'b00, i[1:0], 4'h3}, 16'h0005);
            repeat (3) @(negedge core_clk_i);
            `CHK("event idle", 16'h0000, cnt)
            src_u.drive(2'b01, 1);
            src_u.drive(2'b00, 3);
            repeat (2) begin
                src_u.drive(2'b01, 3);
                src_u.drive(2'b00, 3);
            end
            repeat (4) @(negedge core_clk_i);
            `CHK("event count", ev_exp[i], cnt)
        end
        $display("test event done");
        setup(2'h1, 8'h01, 8'h10, 16'h0000);
        src_u.drive(2'b11, 7);
        src_u.drive(2'b01, 7);
        src_u.drive(2'b00, 4);
        @(negedge core_clk_i);
        `CHK("capture b value", 16'h0003, rb)
        `CHK("width", 16'h0007, ra - rb)
        `CHK("capture b irq", 1, irq_b_n)
        $display("test capture done");
        @(posedge core_clk_i);
        mode <= 2'h0;
        reset_i <= 1'b1;
        @(posedge core_clk_i);
        reset_i <= 1'b0;
        @(negedge core_clk_i);
        `CHK("reset counter", 16'h0000, cnt)
        `CHK("reset registers", 32'h00000000, {ra, rb})
        $display("test reset done");
        end_sim();
    end
    initial begin
        repeat (100000) @(posedge core_clk_i);
        fail_count++;
        end_sim();
    end
endmodule
`default_nettype wire
